// ===== pkg/iesc_pkg.sv
`default_nettype none
package iesc_pkg;

	// ==========================================================
	// Access locations
	localparam logic [1:0] LOC_MEM = 2'h0;
	localparam logic [1:0] LOC_MOD = 2'h1;
	localparam logic [1:0] LOC_EXT = 2'h2;
	localparam int         LOC_W   = 2;

	// ==========================================================
	// Cycle type slots of the cost array
	localparam int SLOT_FETCH  = 0;
	localparam int SLOT_BRANCH = 1;
	localparam int SLOT_STACK  = 2;
	localparam int SLOT_BYTE   = 3;
	localparam int SLOT_WORD   = 4;
	localparam int SLOT_N      = 5;

	// ==========================================================
	// State cost per cycle
	localparam int COST_MEM          = 2;
	localparam int COST_WORD_MOD     = 6;
	localparam int COST_WORD_EXT     = 6;
	localparam int COST_WORD_WAITMUL = 2;
	localparam int COST_BYTE_MOD     = 3;
	localparam int COST_BYTE_EXT     = 3;
	localparam int COST_INTERNAL     = 1;

	// ==========================================================
	// Cycle counts of the built-in instruction classes
	localparam int CNT_ADD_FETCH   = 1;
	localparam int CNT_LONG_FETCH  = 2;
	localparam int CNT_BIT_BYTE    = 2;
	localparam int CNT_CALL_BRANCH = 1;
	localparam int CNT_CALL_STACK  = 1;

	// ==========================================================
	// Instruction classes
	typedef enum logic [2:0] {
		IC_CUSTOM       = 3'h0,
		IC_ADD_REG      = 3'h1,
		IC_ADD_IMM      = 3'h2,
		IC_BIT_SET_ABS  = 3'h3,
		IC_BIT_CLR_ABS  = 3'h4,
		IC_CALL_IND8    = 3'h5,
		IC_BRANCH_D8    = 3'h6
	} iesc_class_e;

endpackage
`default_nettype wire

// ===== rtl/iesc_cycle_cost.sv
`timescale 1ns/100ps
`default_nettype none
module iesc_cycle_cost #(
	parameter int CNT_W   = 4,
	parameter int WAIT_W  = 3,
	parameter int RES_W   = 16,
	parameter bit IS_BYTE = 1'b0
) (
	// Cycle description
	input  wire logic [CNT_W-1:0]  i_count,
	input  wire logic [1:0]        i_loc,
	input  wire logic [WAIT_W-1:0] i_wait,
	// Weighted cost
	output logic      [RES_W-1:0]  o_states
);

	// ==========================================================
	// Per-cycle cost at the accessed location
	wire logic [RES_W-1:0] wait_term;
	wire logic [RES_W-1:0] ext_cost;
	wire logic [RES_W-1:0] mod_cost;
	wire logic [RES_W-1:0] unit_cost;

	assign wait_term = IS_BYTE ? RES_W'(i_wait)
	                           : RES_W'(RES_W'(i_wait) * RES_W'(iesc_pkg::COST_WORD_WAITMUL));
	assign ext_cost  = (IS_BYTE ? RES_W'(iesc_pkg::COST_BYTE_EXT)
	                            : RES_W'(iesc_pkg::COST_WORD_EXT)) + wait_term;
	assign mod_cost  = IS_BYTE ? RES_W'(iesc_pkg::COST_BYTE_MOD)
	                           : RES_W'(iesc_pkg::COST_WORD_MOD);
	// Code 3 is not a location; costed as external so an estimate never comes out short
	assign unit_cost = (i_loc == iesc_pkg::LOC_MEM) ? RES_W'(iesc_pkg::COST_MEM) :
	                   (i_loc == iesc_pkg::LOC_MOD) ? mod_cost : ext_cost;
	assign o_states  = RES_W'(RES_W'(i_count) * unit_cost);

endmodule
`default_nettype wire

// ===== rtl/iesc_exec_counter.sv
`timescale 1ns/100ps
`default_nettype none
module iesc_exec_counter #(
	parameter int CNT_W  = 4,
	parameter int WAIT_W = 3,
	parameter int RES_W  = 16
) (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// Request
	input  wire logic              i_req,
	input  wire logic [2:0]        i_class,
	input  wire logic [WAIT_W-1:0] i_wait,
	// Access locations per cycle type
	input  wire logic [1:0]        i_loc_fetch,
	input  wire logic [1:0]        i_loc_branch,
	input  wire logic [1:0]        i_loc_stack,
	input  wire logic [1:0]        i_loc_byte,
	input  wire logic [1:0]        i_loc_word,
	// Cycle counts for the custom class
	input  wire logic [CNT_W-1:0]  i_cnt_fetch,
	input  wire logic [CNT_W-1:0]  i_cnt_branch,
	input  wire logic [CNT_W-1:0]  i_cnt_stack,
	input  wire logic [CNT_W-1:0]  i_cnt_byte,
	input  wire logic [CNT_W-1:0]  i_cnt_word,
	input  wire logic [CNT_W-1:0]  i_cnt_internal,
	// Result
	output logic                   o_valid,
	output logic      [RES_W-1:0]  o_states,
	output logic                   o_illegal
);

	// ==========================================================
	// Class decode
	wire logic is_custom;
	wire logic is_add;
	wire logic is_bit;
	wire logic is_call;
	wire logic is_branch;
	wire logic is_known;

	assign is_custom = (i_class == iesc_pkg::IC_CUSTOM);
	assign is_add    = (i_class == iesc_pkg::IC_ADD_REG) || (i_class == iesc_pkg::IC_ADD_IMM);
	assign is_bit    = (i_class == iesc_pkg::IC_BIT_SET_ABS)
	                || (i_class == iesc_pkg::IC_BIT_CLR_ABS);
	assign is_call   = (i_class == iesc_pkg::IC_CALL_IND8);
	assign is_branch = (i_class == iesc_pkg::IC_BRANCH_D8);
	assign is_known  = is_custom || is_add || is_bit || is_call || is_branch;

	// ==========================================================
	// Cycle counts per type
	wire logic [CNT_W-1:0] cnt [iesc_pkg::SLOT_N];
	wire logic [1:0]       loc [iesc_pkg::SLOT_N];
	wire logic [CNT_W-1:0] cnt_internal;

	assign cnt[iesc_pkg::SLOT_FETCH] =
		is_custom ? i_cnt_fetch :
		is_add    ? CNT_W'(iesc_pkg::CNT_ADD_FETCH) :
		(is_bit || is_call || is_branch) ?
		            CNT_W'(iesc_pkg::CNT_LONG_FETCH) : CNT_W'(0);
	assign cnt[iesc_pkg::SLOT_BRANCH] =
		is_custom ? i_cnt_branch :
		is_call   ? CNT_W'(iesc_pkg::CNT_CALL_BRANCH) : CNT_W'(0);
	assign cnt[iesc_pkg::SLOT_STACK] =
		is_custom ? i_cnt_stack :
		is_call   ? CNT_W'(iesc_pkg::CNT_CALL_STACK) : CNT_W'(0);
	assign cnt[iesc_pkg::SLOT_BYTE] =
		is_custom ? i_cnt_byte :
		is_bit    ? CNT_W'(iesc_pkg::CNT_BIT_BYTE) : CNT_W'(0);
	assign cnt[iesc_pkg::SLOT_WORD] = is_custom ? i_cnt_word : CNT_W'(0);
	assign cnt_internal             = is_custom ? i_cnt_internal : CNT_W'(0);

	assign loc[iesc_pkg::SLOT_FETCH]  = i_loc_fetch;
	assign loc[iesc_pkg::SLOT_BRANCH] = i_loc_branch;
	assign loc[iesc_pkg::SLOT_STACK]  = i_loc_stack;
	assign loc[iesc_pkg::SLOT_BYTE]   = i_loc_byte;
	assign loc[iesc_pkg::SLOT_WORD]   = i_loc_word;

	// ==========================================================
	// Weighted costs; only the byte slot uses the byte cost table
	wire logic [RES_W-1:0] cost [iesc_pkg::SLOT_N];

	genvar g;
	generate
		for (g = 0; g < iesc_pkg::SLOT_N; g++)
		begin : g_slot
			iesc_cycle_cost #(
				.CNT_W   (CNT_W),
				.WAIT_W  (WAIT_W),
				.RES_W   (RES_W),
				.IS_BYTE (g == iesc_pkg::SLOT_BYTE)
			) u_cost (
				.i_count  (cnt[g]),
				.i_loc    (loc[g]),
				.i_wait   (i_wait),
				.o_states (cost[g])
			);
		end
	endgenerate

	// ==========================================================
	// Sum of all cycle types
	wire logic [RES_W-1:0] internal_cost;
	wire logic [RES_W-1:0] next_states;

	assign internal_cost = RES_W'(RES_W'(cnt_internal) * RES_W'(iesc_pkg::COST_INTERNAL));
	assign next_states   = cost[iesc_pkg::SLOT_FETCH] + cost[iesc_pkg::SLOT_BRANCH]
	                     + cost[iesc_pkg::SLOT_STACK] + cost[iesc_pkg::SLOT_BYTE]
	                     + cost[iesc_pkg::SLOT_WORD] + internal_cost;

	// ==========================================================
	// Result registers; the count holds until the next request
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_valid   <= 1'b0;
			o_states  <= '0;
			o_illegal <= 1'b0;
		end
		else
		begin
			o_valid <= i_req;
			if (i_req)
			begin
				o_states  <= next_states;
				o_illegal <= !is_known;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	wire logic cust_only_none;
	assign cust_only_none = is_custom && (i_cnt_fetch == '0) && (i_cnt_branch == '0)
	                     && (i_cnt_stack == '0) && (i_cnt_internal == '0);

	sequence s_add_req;
		i_req && is_add;
	endsequence
	sequence s_byte_only;
		i_req && cust_only_none && (i_cnt_byte == CNT_W'(1)) && (i_cnt_word == '0);
	endsequence
	sequence s_word_only;
		i_req && cust_only_none && (i_cnt_word == CNT_W'(1)) && (i_cnt_byte == '0);
	endsequence

	AST_ADD_MEM: assert property (s_add_req ##0 (i_loc_fetch == iesc_pkg::LOC_MEM)
		|=> o_valid && (o_states == RES_W'(2)) && !o_illegal)
		else $error("register add on-chip not two states");
	AST_FETCH_MOD: assert property (s_add_req ##0 (i_loc_fetch == iesc_pkg::LOC_MOD)
		|=> o_states == RES_W'(6))
		else $error("fetch from on-chip module not six states");
	AST_FETCH_EXT: assert property (s_add_req ##0 (i_loc_fetch == iesc_pkg::LOC_EXT)
		|=> o_states == RES_W'(6 + 2 * $past(i_wait)))
		else $error("external fetch cost wrong");
	AST_BYTE_EXT: assert property (s_byte_only ##0 (i_loc_byte == iesc_pkg::LOC_EXT)
		|=> o_states == RES_W'(3 + $past(i_wait)))
		else $error("external byte access cost wrong");
	AST_WORD_MOD: assert property (s_word_only ##0 (i_loc_word == iesc_pkg::LOC_MOD)
		|=> o_states == RES_W'(6))
		else $error("word access to module not six states");
	AST_WORD_EXT: assert property (s_word_only ##0 (i_loc_word == iesc_pkg::LOC_EXT)
		|=> o_states == RES_W'(6 + 2 * $past(i_wait)))
		else $error("external word access cost wrong");
	AST_INTERNAL: assert property (i_req && cust_only_none == 1'b0 && is_custom
		&& (i_cnt_fetch == '0) && (i_cnt_branch == '0) && (i_cnt_stack == '0)
		&& (i_cnt_byte == '0) && (i_cnt_word == '0)
		|=> o_states == RES_W'($past(i_cnt_internal)))
		else $error("internal cycles not one state each");
	AST_BIT_SET: assert property (i_req && is_bit && (i_loc_fetch == iesc_pkg::LOC_EXT)
		&& (i_loc_byte == iesc_pkg::LOC_MOD)
		|=> o_states == RES_W'(2 * (6 + 2 * $past(i_wait)) + 6))
		else $error("bit set cost wrong");
	AST_CALL_EXT: assert property (i_req && is_call && (i_loc_fetch == iesc_pkg::LOC_EXT)
		&& (i_loc_branch == iesc_pkg::LOC_EXT) && (i_loc_stack == iesc_pkg::LOC_EXT)
		|=> o_states == RES_W'(4 * (6 + 2 * $past(i_wait))))
		else $error("indirect call cost wrong");
	AST_BRANCH: assert property (i_req && is_branch && (i_loc_fetch == iesc_pkg::LOC_MEM)
		|=> o_valid && (o_states == RES_W'(4)) && !o_illegal)
		else $error("branch not two fetches");
	AST_HOLD: assert property (!i_req |=> !o_valid && $stable(o_states))
		else $error("result changed without request");

endmodule
`default_nettype wire

// ===== sim/iesc_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module iesc_seq_model (
	// Clock
	input  wire logic       i_clk,
	// Request towards the counter
	output logic            o_req,
	output logic [2:0]      o_class,
	output logic [2:0]      o_wait,
	output logic [1:0]      o_loc_fetch,
	output logic [1:0]      o_loc_branch,
	output logic [1:0]      o_loc_stack,
	output logic [1:0]      o_loc_byte,
	output logic [1:0]      o_loc_word,
	output logic [23:0]     o_cnt
);
	// ==========================================================
	// Idle state at time zero
	initial
	begin
		o_req = 1'b0;
		o_class = 3'h0;
		o_wait = 3'h0;
		{o_loc_fetch, o_loc_branch, o_loc_stack, o_loc_byte, o_loc_word} = 10'h000;
		o_cnt = 24'h000000;
	end

	// ==========================================================
	// Request and release, both on the falling edge
	task automatic drive(input logic [2:0] c, input logic [2:0] m, input logic [9:0] l,
		input logic [23:0] n);
		@(negedge i_clk);
		o_class = c;
		o_wait = m;
		{o_loc_fetch, o_loc_branch, o_loc_stack, o_loc_byte, o_loc_word} = l;
		o_cnt = n;
		o_req = 1'b1;
	endtask

	// Class, wait and count fields flip once released so a stray sample shows up in the result
	task automatic idle();
		@(negedge i_clk);
		o_req = 1'b0;
		o_class = ~o_class;
		o_wait = ~o_wait;
		o_cnt = ~o_cnt;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        req;
	logic [2:0]  cls;
	logic [2:0]  wt;
	logic [1:0]  lf, lb, ls, ly, lw;
	logic [23:0] cn;
	logic        o_valid;
	logic [15:0] o_states;
	logic        o_illegal;
	int          n_mismatch = 0;
	int          total_checks = 0;

	iesc_seq_model seq (.i_clk(i_clk), .o_req(req), .o_class(cls), .o_wait(wt),
		.o_loc_fetch(lf), .o_loc_branch(lb), .o_loc_stack(ls), .o_loc_byte(ly),
		.o_loc_word(lw), .o_cnt(cn));
	iesc_exec_counter dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_class(cls),
		.i_wait(wt), .i_loc_fetch(lf), .i_loc_branch(lb), .i_loc_stack(ls),
		.i_loc_byte(ly), .i_loc_word(lw), .i_cnt_fetch(cn[23:20]), .i_cnt_branch(cn[19:16]),
		.i_cnt_stack(cn[15:12]), .i_cnt_byte(cn[11:8]), .i_cnt_word(cn[7:4]),
		.i_cnt_internal(cn[3:0]), .o_valid(o_valid), .o_states(o_states),
		.o_illegal(o_illegal));

	initial
	begin
		forever #4 i_clk = ~i_clk;
	end

	// ==========================================================
	// Checking helpers
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %0d seen %0d", name, exp, seen);
		end
	endtask

	// Own cost table; code 3 is costed as external
	function automatic int cost(input bit is_byte, input logic [1:0] loc, input int m);
		if (loc == 2'h0)
			return 2;
		if (loc == 2'h1)
			return is_byte ? 3 : 6;
		return is_byte ? 3 + m : 6 + 2 * m;
	endfunction

	task automatic summarize();
		$display("mismatches %0d of %0d checks", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One request, result one cycle later, then held while the strobe drops
	task automatic run(input logic [2:0] c, input logic [2:0] m, input logic [9:0] l,
		input logic [23:0] n, input int exp, input logic ill);
		seq.drive(c, m, l, n);
		seq.idle();
		chk("valid", o_valid, 1);
		chk("states", o_states, exp);
		chk("illegal", o_illegal, ill);
		@(negedge i_clk);
		chk("valid_drop", o_valid, 0);
		chk("states_hold", o_states, exp);
		chk("illegal_hold", o_illegal, ill);
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_add();
		for (int c = 1; c <= 2; c++)
			for (int lc = 0; lc < 4; lc++)
				run(c, 3, {lc[1:0], 8'hFF}, 24'hFFFFFF, cost(0, lc, 3), 0);
	endtask

	task automatic s_bit();
		for (int c = 3; c <= 4; c++)
			for (int lc = 1; lc < 3; lc++)
				run(c, 1, {2'h2, 4'h0, lc[1:0], 2'h0}, 0, 16 + 2 * cost(1, lc, 1), 0);
	endtask

	task automatic s_call();
		run(5, 1, 10'h2A0, 0, 32, 0);
		run(5, 7, 10'h2A0, 0, 4 * cost(0, 2, 7), 0);
		run(5, 0, 10'h150, 0, 24, 0);
	endtask

	task automatic s_branch();
		run(6, 7, 10'h1FF, 24'h0FFFFF, 12, 0);
		run(6, 2, 10'h000, 0, 4, 0);
	endtask

	task automatic s_custom();
		int exp;
		exp = cost(0, 0, 7) + 2 * cost(0, 1, 7) + 3 * cost(0, 2, 7) + 4 * cost(1, 3, 7);
		exp = exp + 5 * cost(0, 1, 7) + 15;
		run(0, 7, {2'h0, 2'h1, 2'h2, 2'h3, 2'h1}, 24'h12345F, exp, 0);
		run(0, 7, 10'h3FF, 24'h000009, 9, 0);
		run(0, 0, 10'h000, 24'h000009, 9, 0);
		run(0, 5, 10'h2AA, 24'h000020, 2 * cost(0, 2, 5), 0);
		run(0, 5, 10'h008, 24'h000100, cost(1, 2, 5), 0);
		run(0, 3, 10'h001, 24'h000010, cost(0, 1, 3), 0);
		run(0, 3, 10'h002, 24'h000010, cost(0, 2, 3), 0);
	endtask

	task automatic s_back_to_back();
		seq.drive(7, 0, 10'h000, 24'h111111);
		seq.drive(1, 0, 10'h000, 0);
		chk("illegal_set", o_illegal, 1);
		chk("illegal_states", o_states, 0);
		seq.idle();
		chk("next_valid", o_valid, 1);
		chk("next_states", o_states, 2);
		chk("illegal_clear", o_illegal, 0);
	endtask

	task automatic s_mid_reset();
		run(6, 0, 10'h100, 0, 12, 0);
		i_rst = 1'b1;
		@(negedge i_clk);
		chk("reset_states", o_states, 0);
		chk("reset_valid", o_valid, 0);
		chk("reset_illegal", o_illegal, 0);
		i_rst = 1'b0;
		// First request after a mid-run reset must be taken normally
		run(1, 0, 10'h000, 0, 2, 0);
	endtask

	// ==========================================================
	// Main sequence and hang guard
	initial
	begin
		repeat (4) @(negedge i_clk);
		i_rst = 1'b0;
		chk("rst_valid", o_valid, 0);
		chk("rst_states", o_states, 0);
		chk("rst_illegal", o_illegal, 0);
		s_add();
		s_bit();
		s_call();
		s_branch();
		s_custom();
		s_back_to_back();
		s_mid_reset();
		summarize();
	end

	initial
	begin
		#100000;
		n_mismatch++;
		summarize();
	end
endmodule
`default_nettype wire
